// File: stta_map.svh
// register offsets, field positions, reset values and timing counts of the timer
`ifndef STTA_MAP_SVH
`define STTA_MAP_SVH
// word offsets on the avalon bus (byte address = 4 * index)
`define STTA_IDX_CNT_LO 4'h0
`define STTA_IDX_CNT_HI 4'h1
`define STTA_IDX_CMPA_LO 4'h2
`define STTA_IDX_CMPA_HI 4'h3
`define STTA_IDX_CMPB_LO 4'h4
`define STTA_IDX_CMPB_HI 4'h5
`define STTA_IDX_CAP_LO 4'h6
`define STTA_IDX_CAP_HI 4'h7
`define STTA_IDX_CTRL_A 4'h8
`define STTA_IDX_CTRL_B 4'h9
`define STTA_IDX_FLAG 4'hA
`define STTA_IDX_MASK 4'hB
// control a: [1:0] top select
`define STTA_CA_TOP_LSB 0
// control b: [2:0] clock select, [3] capture edge, [4] noise filter, [5] capture source
`define STTA_CB_CS_LSB 0
`define STTA_CB_EDGE_BIT 3
`define STTA_CB_FILT_BIT 4
`define STTA_CB_SRC_BIT 5
// flag and mask bit positions
`define STTA_FL_OVF 0
`define STTA_FL_MA 1
`define STTA_FL_MB 2
`define STTA_FL_CAP 3
`define STTA_RESET_BYTE 8'h00
`define STTA_RESET_WORD 16'h0000
`define STTA_BOTTOM 16'h0000
`define STTA_MAX 16'hFFFF
`define STTA_TOP_8 16'h00FF
`define STTA_TOP_9 16'h01FF
`define STTA_TOP_10 16'h03FF
`define STTA_FILTER_LEN 4
`define STTA_PRE_BITS 10
`endif

// File: stta_pkg.sv
// types of the sixteen bit timer
package stta_pkg;
  typedef enum logic [1:0] {
    STTA_TOP_FIXED_8 = 2'b00,
    STTA_TOP_FIXED_9 = 2'b01,
    STTA_TOP_CMPA = 2'b10,
    STTA_TOP_CAP = 2'b11
  } stta_top_sel_t;

  typedef struct packed {
    logic [7:0] hold;
    logic [15:0] count_value;
    logic [15:0] compare_value_a;
    logic [15:0] compare_value_b;
    logic [15:0] cmpa_buf;
    logic [15:0] cmpb_buf;
    logic [15:0] capture_value;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [3:0] flags;
    logic [3:0] mask;
    logic [9:0] prescale;
    logic [2:0] ext_sync;
    logic [3:0] cap_hist;
    logic cap_level;
    logic cap_prev;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
    logic cmp_out_a;
    logic cmp_out_b;
    logic bottom;
  } stta_state_t;
endpackage

// File: stta_timer.sv
// sixteen bit timer with shared high byte holding register, avalon slave
//
// Operation
// RULE1 - one eight bit holding register shared by counter, compares and capture
// RULE2 - low byte write loads held high byte and written low byte together
// RULE3 - low byte read copies register high byte into holding register
// RULE4 - compare reads return own high byte, holding register untouched
// RULE5 - software writes high byte first, reads low byte first
// RULE6 - main code disables interrupts around two byte accesses
// RULE7 - bottom signalled when counter becomes zero
// RULE8 - all ones counter value is the maximum
// RULE9 - top is a fixed value, compare a or capture register
// RULE10 - compare a as top is double buffered and drives no output
// RULE11 - buffered compares match counter, set flag, feed output pin
// RULE12 - clock from prescaler taps or external pin edge; stopped if none
// RULE13 - capture stores counter on pin or comparator edge, optional filter
// RULE14 - four interrupt flags in shared flag register, masked individually
// RULE15 - control registers accessed directly in single bytes
// RULE16 - clock select zero stops counter, cpu access still works
// RULE17 - cpu counter write beats clear or count in same cycle
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`include "stta_map.svh"
`timescale 1ns/1ps
`default_nettype none
module stta_timer (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic external_count_pin_in,
  input wire logic capture_pin_in,
  input wire logic comparator_in,
  output logic compare_output_a_out,
  output logic compare_output_b_out,
  output logic bottom_out,
  output logic irq_out
);
  stta_pkg::stta_state_t s_r;
  stta_pkg::stta_state_t s_nxt;

  // ==========================================================
  // helpers
  function automatic logic [15:0] stta_top_of(input logic [1:0] sel,
                                               input logic [15:0] cmpa,
                                               input logic [15:0] cap);
    unique case (stta_pkg::stta_top_sel_t'(sel))
      stta_pkg::STTA_TOP_FIXED_8: stta_top_of = `STTA_TOP_8;
      stta_pkg::STTA_TOP_FIXED_9: stta_top_of = `STTA_TOP_9;
      stta_pkg::STTA_TOP_CMPA: stta_top_of = cmpa;
      stta_pkg::STTA_TOP_CAP: stta_top_of = cap;
    endcase
  endfunction

  function automatic logic stta_lane_ok(input logic [3:0] be);
    stta_lane_ok = be[0];
  endfunction

  // prescaler taps and external edges feed one tick; select zero holds the counter
  function automatic logic stta_tick_of(input logic [2:0] sel,
                                        input logic [9:0] pre,
                                        input logic rise,
                                        input logic fall);
    unique case (sel)
      3'h0: stta_tick_of = 1'b0; // [RULE16] [RULE12]
      3'h1: stta_tick_of = 1'b1;
      3'h2: stta_tick_of = (pre[2:0] == 3'h7);
      3'h3: stta_tick_of = (pre[5:0] == 6'h3F);
      3'h4: stta_tick_of = (pre[7:0] == 8'hFF);
      3'h5: stta_tick_of = (pre == 10'h3FF);
      3'h6: stta_tick_of = fall; // [RULE12]
      3'h7: stta_tick_of = rise; // [RULE12]
    endcase
  endfunction

  // one cycle pulse on the chosen edge of a sampled level
  function automatic logic stta_edge(input logic now,
                                     input logic was,
                                     input logic rising);
    stta_edge = rising ? (now && !was) : (!now && was);
  endfunction

  // four equal samples move the level, anything mixed keeps the old one
  function automatic logic stta_filter(input logic [3:0] hist,
                                       input logic en,
                                       input logic last);
    if (!en) begin
      stta_filter = hist[0];
    end else if (hist == 4'hF) begin
      stta_filter = 1'b1;
    end else if (hist == 4'h0) begin
      stta_filter = 1'b0;
    end else begin
      stta_filter = last;
    end
  endfunction

  // a stopped timer never ticks, so it never matches either
  function automatic logic stta_match(input logic [15:0] cnt,
                                      input logic [15:0] cmp,
                                      input logic tk);
    stta_match = tk && (cnt == cmp);
  endfunction

  // sixteen bit commit: held high byte over the low byte just written
  function automatic logic [15:0] stta_join(input logic [7:0] hi,
                                            input logic [7:0] lo);
    stta_join = {hi, lo};
  endfunction

  // capture register holds top in mode three, so events may not overwrite it
  function automatic logic stta_cap_locked(input logic [7:0] ctrl);
    stta_cap_locked = (ctrl[`STTA_CA_TOP_LSB +: 2] == 2'b11);
  endfunction

  // ==========================================================
  // next state
  // bus decode
  logic [3:0] idx;
  logic wr_ok;
  logic rd_ok;
  // clock select and counter
  logic tick;
  logic ext_rise;
  logic ext_fall;
  logic [2:0] cs;
  logic [15:0] top;
  logic [15:0] cnt_next;
  // capture path
  logic cap_src;
  logic cap_in;
  logic cap_edge;
  logic [3:0] ev;
  logic [7:0] wb;
  always_comb begin
    s_nxt = s_r;
    idx = avs_address_in[5:2];
    wr_ok = avs_write_in && stta_lane_ok(avs_byteenable_in);
    rd_ok = avs_read_in && !s_r.rvalid;
    wb = avs_writedata_in[7:0];
    cs = s_r.ctrl_b[`STTA_CB_CS_LSB +: 3];

    // ========================================================
    // clock select
    s_nxt.prescale = s_r.prescale + 10'h001;
    s_nxt.ext_sync = {s_r.ext_sync[1:0], external_count_pin_in};
    // edge detect looks only at the second and third stages
    ext_rise = stta_edge(s_r.ext_sync[1], s_r.ext_sync[2], 1'b1);
    ext_fall = stta_edge(s_r.ext_sync[1], s_r.ext_sync[2], 1'b0);
    // the prescaler runs free, so a first prescaled tick may come early
    tick = stta_tick_of(cs, s_r.prescale, ext_rise, ext_fall); // [RULE12] [RULE16]

    // ========================================================
    // counter
    top = stta_top_of(s_r.ctrl_a[`STTA_CA_TOP_LSB +: 2],
                      s_r.cmpa_buf, s_r.capture_value); // [RULE9] [RULE10]
    ev = 4'h0;
    cnt_next = s_r.count_value;
    if (tick) begin
      // all ones always wraps, whatever top says
      if (s_r.count_value == top || s_r.count_value == `STTA_MAX) begin // [RULE8]
        cnt_next = `STTA_BOTTOM;
        ev[`STTA_FL_OVF] = 1'b1;
        // compare values reload at top, so a new period never glitches
        s_nxt.cmpa_buf = s_r.compare_value_a; // [RULE10]
        s_nxt.cmpb_buf = s_r.compare_value_b;
      end else begin
        cnt_next = s_r.count_value + 16'h0001;
      end
    end

    // ========================================================
    // compare units, against the buffered values
    if (stta_match(s_r.count_value, s_r.cmpa_buf, tick)) begin // [RULE11]
      ev[`STTA_FL_MA] = 1'b1;
    end
    if (stta_match(s_r.count_value, s_r.cmpb_buf, tick)) begin // [RULE11]
      ev[`STTA_FL_MB] = 1'b1;
    end

    // ========================================================
    // capture unit, optional four sample agreement filter
    cap_src = s_r.ctrl_b[`STTA_CB_SRC_BIT] ? comparator_in : capture_pin_in;
    s_nxt.cap_hist = {s_r.cap_hist[2:0], cap_src};
    cap_in = stta_filter(s_r.cap_hist, s_r.ctrl_b[`STTA_CB_FILT_BIT],
                         s_r.cap_level); // [RULE13]
    s_nxt.cap_level = cap_in;
    s_nxt.cap_prev = s_r.cap_level;
    cap_edge = stta_edge(s_r.cap_level, s_r.cap_prev, s_r.ctrl_b[`STTA_CB_EDGE_BIT]);
    if (cap_edge && !stta_cap_locked(s_r.ctrl_a)) begin // [RULE13]
      s_nxt.capture_value = s_r.count_value;
      ev[`STTA_FL_CAP] = 1'b1;
    end

    // ========================================================
    // register bus
    // a read is answered one edge after it appears; rvalid blocks a repeat
    s_nxt.rvalid = rd_ok;
    s_nxt.rdata = `STTA_RESET_BYTE;
    if (wr_ok) begin
      unique case (idx)
        `STTA_IDX_CNT_HI, `STTA_IDX_CMPA_HI, `STTA_IDX_CMPB_HI, `STTA_IDX_CAP_HI: begin
          // every high index lands in the one shared byte
          s_nxt.hold = wb; // [RULE1]
        end
        `STTA_IDX_CNT_LO: cnt_next = stta_join(s_r.hold, wb); // [RULE2] [RULE17]
        `STTA_IDX_CMPA_LO: s_nxt.compare_value_a = stta_join(s_r.hold, wb); // [RULE2]
        `STTA_IDX_CMPB_LO: s_nxt.compare_value_b = stta_join(s_r.hold, wb); // [RULE2]
        `STTA_IDX_CAP_LO: begin
          // writable only while it sets top
          if (stta_cap_locked(s_r.ctrl_a)) begin
            s_nxt.capture_value = stta_join(s_r.hold, wb); // [RULE2]
          end
        end
        `STTA_IDX_CTRL_A: s_nxt.ctrl_a = wb; // [RULE15]
        `STTA_IDX_CTRL_B: s_nxt.ctrl_b = wb; // [RULE15]
        `STTA_IDX_MASK: s_nxt.mask = wb[3:0]; // [RULE14]
        default: ;
      endcase
    end
    s_nxt.count_value = cnt_next;
    s_nxt.flags = s_r.flags;
    if (rd_ok) begin
      unique case (idx)
        `STTA_IDX_CNT_LO: begin
          s_nxt.rdata = s_r.count_value[7:0];
          s_nxt.hold = s_r.count_value[15:8]; // [RULE3]
        end
        `STTA_IDX_CAP_LO: begin
          s_nxt.rdata = s_r.capture_value[7:0];
          s_nxt.hold = s_r.capture_value[15:8]; // [RULE3]
        end
        `STTA_IDX_CMPA_LO: s_nxt.rdata = s_r.compare_value_a[7:0];
        `STTA_IDX_CMPB_LO: s_nxt.rdata = s_r.compare_value_b[7:0];
        // compare high bytes bypass the holding register
        `STTA_IDX_CMPA_HI: s_nxt.rdata = s_r.compare_value_a[15:8]; // [RULE4]
        `STTA_IDX_CMPB_HI: s_nxt.rdata = s_r.compare_value_b[15:8]; // [RULE4]
        `STTA_IDX_CNT_HI, `STTA_IDX_CAP_HI: s_nxt.rdata = s_r.hold; // [RULE1]
        `STTA_IDX_CTRL_A: s_nxt.rdata = s_r.ctrl_a; // [RULE15]
        `STTA_IDX_CTRL_B: s_nxt.rdata = s_r.ctrl_b; // [RULE15]
        `STTA_IDX_FLAG: begin
          s_nxt.rdata = {4'h0, s_r.flags};
          s_nxt.flags = 4'h0; // read clears
        end
        `STTA_IDX_MASK: s_nxt.rdata = {4'h0, s_r.mask};
        default: s_nxt.rdata = `STTA_RESET_BYTE;
      endcase
    end

    // ========================================================
    // interrupt flags
    // new events win over the read clear
    s_nxt.flags = s_nxt.flags | ev; // [RULE14]
    // irq registers on the same edge as the flags it is made from
    s_nxt.irq = |(s_nxt.flags & s_nxt.mask); // [RULE14]

    // ========================================================
    // waveform outputs and bottom
    // every match of b, and of a unless compare a sets top, toggles, even while its flag is still unread
    if (ev[`STTA_FL_MA] && s_r.ctrl_a[1:0] != 2'b10) begin // [RULE10] [RULE11]
      s_nxt.cmp_out_a = !s_r.cmp_out_a;
    end
    if (ev[`STTA_FL_MB]) begin // [RULE11]
      s_nxt.cmp_out_b = !s_r.cmp_out_b;
    end
    s_nxt.bottom = (s_nxt.count_value == `STTA_BOTTOM); // [RULE7]
  end

  // ==========================================================
  // registers
  // every field clears together; bottom shows one edge after release
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  // waitrequest stays combinational: a read must wait in the cycle it appears
  assign avs_readdata_out = {24'h000000, s_r.rdata};
  assign avs_waitrequest_out = (avs_read_in && !s_r.rvalid);
  assign compare_output_a_out = s_r.cmp_out_a;
  assign compare_output_b_out = s_r.cmp_out_b;
  assign bottom_out = s_r.bottom;
  assign irq_out = s_r.irq;
endmodule
`default_nettype wire

// File: stta_timer_props.sv
// bus timing and interrupt checks of the sixteen bit timer
`include "stta_map.svh"
`timescale 1ns/1ps
`default_nettype none
module stta_timer_chk (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // ==========
  // read handshake
  sequence read_start;
    $rose(avs_read_in);
  endsequence
  sequence read_first;
    avs_read_in && avs_waitrequest_out ##1 avs_read_in;
  endsequence
  sequence read_done;
    avs_read_in && !avs_waitrequest_out;
  endsequence
  a_wait_idle: assert property (!avs_read_in |-> !avs_waitrequest_out)
    else $error("waitrequest high without a read");
  a_read_wait: assert property (read_start |-> avs_waitrequest_out)
    else $error("read answered without its wait cycle");
  a_read_answer: assert property (read_first |-> !avs_waitrequest_out)
    else $error("read not answered after one wait cycle");
  a_wait_once: assert property (avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("waitrequest high two cycles running");
  a_write_nowait: assert property (avs_write_in |-> !avs_waitrequest_out)
    else $error("write was made to wait");
  a_upper_zero: assert property (read_done |-> avs_readdata_out[31:8] == 24'h000000)
    else $error("read data wider than one byte");
  a_unmapped_zero: assert property ((read_done and (avs_address_in[5:2] > `STTA_IDX_MASK))
    |-> avs_readdata_out == 32'h00000000)
    else $error("unmapped read returned data");
  // irq registers together with the mask, so a cleared mask shows at the next edge; the check looks two edges later
  a_mask_irq: assert property (avs_write_in && avs_address_in[5:2] == `STTA_IDX_MASK
    && avs_byteenable_in[0] && avs_writedata_in[3:0] == 4'h0 |-> ##2 !irq_out)
    else $error("irq high with all sources masked");
endmodule
bind stta_timer stta_timer_chk chk (.sys_clk_in, .reset_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out,
  .avs_waitrequest_out, .irq_out);
`default_nettype wire

// File: stta_pin_model.sv
// capture event source standing outside the timer
`timescale 1ns/1ps
`default_nettype none
module stta_pin_model (
  input wire logic sys_clk_in,
  input wire logic fire_in,
  output logic capture_pin_out
);
  int n = 0;
  // long pulse so it also survives the four sample filter
  always @(posedge sys_clk_in) begin
    if (fire_in) n <= 12;
    else if (n > 0) n <= n - 1;
  end
  assign capture_pin_out = (n > 0);
endmodule
`default_nettype wire

// File: tb_sixteen_bit_timer_access.sv
// self-checking bench of the sixteen bit timer
`include "stta_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_sixteen_bit_timer_access;
  logic clk = 0, rst = 1, rd = 0, wr = 0, fire = 0, ext = 0, cap, wt, a_out, b_out, bot, irq;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h00000000, rdat;
  logic [7:0] got;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  stta_timer dut (.sys_clk_in(clk), .reset_in(rst), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_byteenable_in(4'h1), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .external_count_pin_in(ext), .capture_pin_in(cap),
    .comparator_in(1'b0), .compare_output_a_out(a_out), .compare_output_b_out(b_out),
    .bottom_out(bot), .irq_out(irq));
  stta_pin_model pins (.sys_clk_in(clk), .fire_in(fire), .capture_pin_out(cap));
  initial begin
    forever #5 clk = ~clk;
  end
  // ==========
  // verdict, compare and bus tasks
  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] exp, input logic [7:0] act);
    cmp_count++;
    if (act !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, act);
    end
  endtask
  // wait sampled at the edge itself, before the design updates
  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk);
    adr <= {idx, 2'b00};
    wd <= {24'h000000, d};
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do @(posedge clk); while (wt !== 1'b0);
    got = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk8(exp, got);
  endtask
  // ==========
  // scenarios
  task automatic t_pair();
    bus(1'b1, `STTA_IDX_CTRL_B, 8'h00);
    bus(1'b1, `STTA_IDX_CNT_HI, 8'h12);
    bus(1'b1, `STTA_IDX_CNT_LO, 8'h34);
    rd_chk(`STTA_IDX_CNT_LO, 8'h34);
    rd_chk(`STTA_IDX_CNT_HI, 8'h12);
  endtask
  task automatic t_shared();
    bus(1'b1, `STTA_IDX_CMPA_HI, 8'hAB);
    bus(1'b1, `STTA_IDX_CMPB_LO, 8'hCD);
    rd_chk(`STTA_IDX_CNT_LO, 8'h34);
    rd_chk(`STTA_IDX_CMPB_HI, 8'hAB);
    rd_chk(`STTA_IDX_CMPB_LO, 8'hCD);
    rd_chk(`STTA_IDX_CNT_HI, 8'h12);
  endtask
  task automatic t_ctrl();
    bus(1'b1, `STTA_IDX_CTRL_A, 8'h02);
    rd_chk(`STTA_IDX_CTRL_A, 8'h02);
    rd_chk(4'hC, 8'h00);
    bus(1'b1, `STTA_IDX_CTRL_A, 8'h00);
  endtask
  task automatic t_count();
    bus(1'b1, `STTA_IDX_CNT_HI, 8'h00);
    bus(1'b1, `STTA_IDX_CNT_LO, 8'h00);
    bus(1'b1, `STTA_IDX_CMPA_LO, 8'h10);
    bus(1'b1, `STTA_IDX_CMPB_LO, 8'h20);
    chk8(8'h01, {7'h00, bot});
    rd_chk(`STTA_IDX_FLAG, 8'h00);
    bus(1'b1, `STTA_IDX_MASK, 8'h07);
    bus(1'b1, `STTA_IDX_CTRL_B, 8'h01);
    // two wraps of the 0x00FF range reach both compares after reload
    repeat (600) @(posedge clk);
    chk8(8'h01, {7'h00, irq});
    bus(1'b1, `STTA_IDX_CTRL_B, 8'h00);
    rd_chk(`STTA_IDX_FLAG, 8'h07);
    repeat (3) @(posedge clk);
    chk8(8'h00, {7'h00, irq});
    bus(1'b1, `STTA_IDX_MASK, 8'h00);
    // three matches each for a and b leave both outputs high
    chk8(8'h03, {6'h00, a_out, b_out});
  endtask
  task automatic t_ext();
    bus(1'b1, `STTA_IDX_CNT_HI, 8'h00);
    bus(1'b1, `STTA_IDX_CNT_LO, 8'h00);
    bus(1'b1, `STTA_IDX_CTRL_B, 8'h07);
    repeat (3) begin
      @(posedge clk);
      ext <= 1'b1;
      repeat (3) @(posedge clk);
      ext <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    bus(1'b1, `STTA_IDX_CTRL_B, 8'h00);
    rd_chk(`STTA_IDX_CNT_LO, 8'h03);
    rd_chk(`STTA_IDX_CNT_HI, 8'h00);
  endtask
  task automatic t_capture();
    bus(1'b1, `STTA_IDX_CTRL_B, 8'h18);
    bus(1'b1, `STTA_IDX_CNT_HI, 8'h05);
    bus(1'b1, `STTA_IDX_CNT_LO, 8'h67);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (20) @(posedge clk);
    chk8(8'h00, {7'h00, bot});
    rd_chk(`STTA_IDX_CAP_LO, 8'h67);
    rd_chk(`STTA_IDX_CAP_HI, 8'h05);
    rd_chk(`STTA_IDX_FLAG, 8'h08);
  endtask
  // ==========
  // main sequence and hang guard
  initial begin
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 6000) begin
        error_cnt++;
        print_verdict();
      end
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_pair();
    t_shared();
    t_ctrl();
    t_count();
    t_ext();
    t_capture();
    print_verdict();
  end
endmodule
`default_nettype wire
